// file: core/nalu_datapath.sv
/*
  Nibble datapath: working register, carry flag and logic unit, paced
  by a divide-by-three instruction clock. Assumes the instruction
  decoder holds op and operands steady through each machine cycle and
  that memory and port sit outside, fed by the write pulses.
*/
`timescale 1ns/1ps
`include "nalu_map.svh"

module nalu_datapath (
  input  wire logic                        clk_in,        // System clock, 100 MHz
  input  wire logic                        reset_n_in,    // Async reset, active low
  input  wire nalu_pkg::nalu_op_t          op_in,         // Decoded operation
  input  wire logic [`NALU_WIDTH-1:0]      mem_in,        // Memory nibble at pointer
  input  wire logic [`NALU_WIDTH-1:0]      imm_in,        // Immediate nibble
  input  wire logic [`NALU_BIT_SEL_W-1:0]  bit_sel_in,    // Bit number for bit ops
  input  wire logic [`NALU_WIDTH-1:0]      port_in,       // Port input nibble
  output logic                             mcycle_out,    // Last phase: op taken
  output logic [`NALU_WIDTH-1:0]           acc_out,       // Working register
  output logic                             carry_out,     // Carry flag
  output logic                             skip_out,      // Compare matched
  output logic [`NALU_WIDTH-1:0]           mem_data_out,  // Nibble to memory
  output logic                             mem_we_out,    // Memory write pulse
  output logic [`NALU_WIDTH-1:0]           port_data_out, // Nibble to port
  output logic                             port_we_out    // Port write pulse
);

  // ----------------------------------------------------------------
  // State and logic unit
  // ----------------------------------------------------------------
  nalu_pkg::nalu_state_t state_q;  // Registered state
  nalu_pkg::nalu_state_t state_d;  // Next state
  logic                  exec;     // Operation taken at this edge

  nalu_unit_if unit_bus ();

  nalu_logic_unit u_logic (
    .u (unit_bus.unit)
  );

  // Feed the unit from the held decoder inputs, with A and carry from the state register
  assign unit_bus.op      = op_in;
  assign unit_bus.a       = state_q.acc;
  assign unit_bus.m       = mem_in;
  assign unit_bus.imm     = imm_in;
  assign unit_bus.cin     = state_q.carry_flag;
  assign unit_bus.bit_sel = bit_sel_in;

  // Operations complete on the last phase only, so the decoder
  // has two spare clocks to settle its operands
  assign exec = (state_q.phase == nalu_pkg::NALU_PH_2);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d         = state_q;
    state_d.mem_we  = 1'b0;
    state_d.port_we = 1'b0;
    // Divide-by-three phase ring
    case (state_q.phase)
      nalu_pkg::NALU_PH_0: state_d.phase = nalu_pkg::NALU_PH_1;
      nalu_pkg::NALU_PH_1: state_d.phase = nalu_pkg::NALU_PH_2;
      nalu_pkg::NALU_PH_2: state_d.phase = nalu_pkg::NALU_PH_0;
      default:             state_d.phase = nalu_pkg::NALU_PH_0;
    endcase
    if (exec)
    begin
      // Skip lasts one machine cycle, for the next fetch to see
      state_d.skip = 1'b0;
      case (op_in)
        // Plain adds overflow silently; carry stays as it was
        nalu_pkg::NALU_OP_ADD_IMM,
        nalu_pkg::NALU_OP_ADD_MEM:
          state_d.acc = unit_bus.result;
        nalu_pkg::NALU_OP_ADD_MEM_CARRY:
        begin
          state_d.acc        = unit_bus.result;
          state_d.carry_flag = unit_bus.cout;
        end
        nalu_pkg::NALU_OP_AND_MEM,
        nalu_pkg::NALU_OP_OR_MEM,
        nalu_pkg::NALU_OP_LOAD_IMM,
        nalu_pkg::NALU_OP_LOAD_MEM:
          state_d.acc = unit_bus.result;
        nalu_pkg::NALU_OP_CMP_IMM,
        nalu_pkg::NALU_OP_CMP_MEM:
          state_d.skip = unit_bus.equal;
        nalu_pkg::NALU_OP_ROT_RIGHT:
        begin
          state_d.acc        = unit_bus.result;
          state_d.carry_flag = unit_bus.cout;
        end
        nalu_pkg::NALU_OP_SET_CARRY:
          state_d.carry_flag = 1'b1;
        nalu_pkg::NALU_OP_CLEAR_CARRY:
          state_d.carry_flag = 1'b0;
        nalu_pkg::NALU_OP_STORE_MEM:
        begin
          state_d.mem_data = state_q.acc;
          state_d.mem_we   = 1'b1;
        end
        // Exchange: old A goes out while memory comes in
        nalu_pkg::NALU_OP_XCH_MEM:
        begin
          state_d.acc      = mem_in;
          state_d.mem_data = state_q.acc;
          state_d.mem_we   = 1'b1;
        end
        nalu_pkg::NALU_OP_BIT_SET,
        nalu_pkg::NALU_OP_BIT_CLEAR:
        begin
          state_d.mem_data = unit_bus.result;
          state_d.mem_we   = 1'b1;
        end
        nalu_pkg::NALU_OP_PORT_IN:
          state_d.acc = port_in;
        nalu_pkg::NALU_OP_PORT_OUT:
        begin
          state_d.port_data = state_q.acc;
          state_d.port_we   = 1'b1;
        end
        // No-op and unknown codes change nothing but the skip clear above
        default:
          state_d.acc = state_q.acc;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_q.phase      <= nalu_pkg::NALU_PH_0;
      state_q.acc        <= `NALU_ACC_RESET;
      state_q.carry_flag <= `NALU_CARRY_RESET;
      state_q.skip       <= `NALU_SKIP_RESET;
      state_q.mem_data   <= `NALU_MEM_RESET;
      state_q.mem_we     <= 1'b0;
      state_q.port_data  <= `NALU_PORT_RESET;
      state_q.port_we    <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from the state register
  // ----------------------------------------------------------------
  assign mcycle_out    = exec;
  assign acc_out       = state_q.acc;
  assign carry_out     = state_q.carry_flag;
  assign skip_out      = state_q.skip;
  assign mem_data_out  = state_q.mem_data;
  assign mem_we_out    = state_q.mem_we;
  assign port_data_out = state_q.port_data;
  assign port_we_out   = state_q.port_we;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  // Reference sum for add-with-carry, kept apart from the unit
  logic [`NALU_WIDTH:0] ref_sum;
  assign ref_sum = {1'b0, mem_in} + {1'b0, state_q.acc} + {4'h0, state_q.carry_flag};

  a_carry_from_add:
    assert property ((exec && op_in == nalu_pkg::NALU_OP_ADD_MEM_CARRY)
                     |=> carry_out == $past(ref_sum[`NALU_WIDTH]))
    else $error("carry not taken from add-with-carry");

  a_add_carry_sum:
    assert property ((exec && op_in == nalu_pkg::NALU_OP_ADD_MEM_CARRY)
                     |=> acc_out == $past(ref_sum[`NALU_WIDTH-1:0]))
    else $error("add-with-carry result wrong");

  a_add_keeps_carry:
    assert property ((exec && (op_in == nalu_pkg::NALU_OP_ADD_IMM ||
                               op_in == nalu_pkg::NALU_OP_ADD_MEM))
                     |=> $stable(carry_out) && acc_out == $past(state_q.acc + (
                         op_in == nalu_pkg::NALU_OP_ADD_IMM ? imm_in : mem_in)))
    else $error("plain add changed carry or sum wrong");

  a_rotate_bit_zero:
    assert property ((exec && op_in == nalu_pkg::NALU_OP_ROT_RIGHT)
                     |=> carry_out == $past(acc_out[0]) &&
                         acc_out == {$past(carry_out), $past(acc_out[`NALU_WIDTH-1:1])})
    else $error("rotate through carry wrong");

  a_set_carry_only:
    assert property ((exec && op_in == nalu_pkg::NALU_OP_SET_CARRY)
                     |=> carry_out && $stable(acc_out) && !mem_we_out)
    else $error("set carry wrong");

  a_clear_carry_only:
    assert property ((exec && op_in == nalu_pkg::NALU_OP_CLEAR_CARRY)
                     |=> !carry_out && $stable(acc_out) && !mem_we_out)
    else $error("clear carry wrong");

  a_mcycle_period:
    assert property (mcycle_out |=> !mcycle_out ##1 !mcycle_out ##1 mcycle_out)
    else $error("machine cycle not three clocks");

  a_idle_phase_hold:
    assert property (!mcycle_out |=> $stable(acc_out) && $stable(carry_out))
    else $error("state changed outside last phase");

  a_and_result:
    assert property ((exec && op_in == nalu_pkg::NALU_OP_AND_MEM)
                     |=> acc_out == ($past(acc_out) & $past(mem_in)))
    else $error("AND result wrong");

  a_load_mem_acc:
    assert property ((exec && op_in == nalu_pkg::NALU_OP_LOAD_MEM)
                     |=> acc_out == $past(mem_in))
    else $error("load from memory wrong");

  c_add_carry_out:
    cover property (exec && op_in == nalu_pkg::NALU_OP_ADD_MEM_CARRY
                    ##1 carry_out);
  c_rotate:
    cover property (exec && op_in == nalu_pkg::NALU_OP_ROT_RIGHT && acc_out[0]);
  c_set_then_clear:
    cover property (exec && op_in == nalu_pkg::NALU_OP_SET_CARRY ##3
                    exec && op_in == nalu_pkg::NALU_OP_CLEAR_CARRY);

endmodule // nalu_datapath

// file: core/nalu_logic_unit.sv
/*
  Combinational 4-bit nalu_logic_unit: add, compare, AND, OR, rotate,
  and bit manipulation. Assumes the core registers all results.
*/
`timescale 1ns/1ps
`include "nalu_map.svh"

module nalu_logic_unit (
  nalu_unit_if.unit u
);

  // ----------------------------------------------------------------
  // Bit mask decode, used by set and clear
  // ----------------------------------------------------------------
  function automatic logic [`NALU_WIDTH-1:0] nalu_mask(
    input logic [`NALU_BIT_SEL_W-1:0] sel
  );
    nalu_mask = 4'h1 << sel;
  endfunction

  logic [`NALU_WIDTH-1:0] operand;   // Immediate or memory
  logic [`NALU_WIDTH:0]   sum;       // Sum with carry out
  logic [`NALU_WIDTH-1:0] and_bits;  // Bitwise AND
  logic [`NALU_WIDTH-1:0] or_bits;   // Bitwise OR
  logic                   use_cin;   // Only add-with-carry adds it

  // Per-bit logic lanes
  genvar gi;
  generate
    for (gi = 0; gi < `NALU_WIDTH; gi = gi + 1)
    begin : g_lane
      assign and_bits[gi] = u.a[gi] & operand[gi];
      assign or_bits[gi]  = u.a[gi] | operand[gi];
    end
  endgenerate

  // Immediate forms take n, all others the memory nibble
  assign operand = (u.op == nalu_pkg::NALU_OP_ADD_IMM ||
                    u.op == nalu_pkg::NALU_OP_CMP_IMM ||
                    u.op == nalu_pkg::NALU_OP_LOAD_IMM) ? u.imm : u.m;
  assign use_cin = (u.op == nalu_pkg::NALU_OP_ADD_MEM_CARRY);
  // Carry-in widened so the fifth bit catches the carry out
  assign sum     = {1'b0, u.a} + {1'b0, operand} + {4'h0, use_cin & u.cin};
  assign u.equal = (u.a == operand);

  // Result selection
  always_comb
  begin
    u.result = u.a;
    u.cout   = u.cin;
    case (u.op)
      nalu_pkg::NALU_OP_ADD_IMM,
      nalu_pkg::NALU_OP_ADD_MEM:       u.result = sum[`NALU_WIDTH-1:0];
      nalu_pkg::NALU_OP_ADD_MEM_CARRY:
      begin
        u.result = sum[`NALU_WIDTH-1:0];
        u.cout   = sum[`NALU_WIDTH];
      end
      nalu_pkg::NALU_OP_AND_MEM:       u.result = and_bits;
      nalu_pkg::NALU_OP_OR_MEM:        u.result = or_bits;
      nalu_pkg::NALU_OP_ROT_RIGHT:
      begin
        u.result = {u.cin, u.a[`NALU_WIDTH-1:1]};
        u.cout   = u.a[0];
      end
      nalu_pkg::NALU_OP_LOAD_IMM,
      nalu_pkg::NALU_OP_LOAD_MEM:      u.result = operand;
      nalu_pkg::NALU_OP_BIT_SET:       u.result = u.m | nalu_mask(u.bit_sel);
      nalu_pkg::NALU_OP_BIT_CLEAR:     u.result = u.m & ~nalu_mask(u.bit_sel);
      default:                         u.result = u.a;
    endcase
  end

endmodule // nalu_logic_unit

// file: core/nalu_map.svh
/*
  Constants of the nibble datapath: widths, reset values and the
  machine-cycle timing. Assumes it is included by bare name, once per unit.
*/
`ifndef NALU_MAP_SVH
`define NALU_MAP_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define NALU_WIDTH        4
`define NALU_BIT_SEL_W    2
`define NALU_OP_W         5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define NALU_ACC_RESET    4'h0
`define NALU_CARRY_RESET  1'b0
`define NALU_SKIP_RESET   1'b0
`define NALU_MEM_RESET    4'h0
`define NALU_PORT_RESET   4'h0

// ----------------------------------------------------------------
// Timing: system clocks per machine cycle
// ----------------------------------------------------------------
`define NALU_CLKS_PER_MCYCLE 3

`endif

// file: core/nalu_pkg.sv
/*
  Types of the nibble datapath: operation codes, cycle phases and the
  packed state record. Assumes nalu_map.svh is on the include path.
*/
`include "nalu_map.svh"

package nalu_pkg;

  // ----------------------------------------------------------------
  // Operations issued by the instruction decoder
  // ----------------------------------------------------------------
  typedef enum logic [`NALU_OP_W-1:0] {
    NALU_OP_NOP           = 5'h00,  // No datapath effect
    NALU_OP_ADD_IMM       = 5'h01,  // A = A + n, carry kept
    NALU_OP_ADD_MEM       = 5'h02,  // A = A + M, carry kept
    NALU_OP_ADD_MEM_CARRY = 5'h03,  // A = A + M + carry, carry updated
    NALU_OP_AND_MEM       = 5'h04,  // A = A & M
    NALU_OP_OR_MEM        = 5'h05,  // A = A | M
    NALU_OP_CMP_IMM       = 5'h06,  // Skip when A == n
    NALU_OP_CMP_MEM       = 5'h07,  // Skip when A == M
    NALU_OP_ROT_RIGHT     = 5'h08,  // Rotate right through carry
    NALU_OP_SET_CARRY     = 5'h09,  // Carry = 1
    NALU_OP_CLEAR_CARRY   = 5'h0A,  // Carry = 0
    NALU_OP_LOAD_IMM      = 5'h0B,  // A = n
    NALU_OP_LOAD_MEM      = 5'h0C,  // A = M
    NALU_OP_STORE_MEM     = 5'h0D,  // M = A
    NALU_OP_XCH_MEM       = 5'h0E,  // A <-> M
    NALU_OP_BIT_SET       = 5'h0F,  // M = M | bit
    NALU_OP_BIT_CLEAR     = 5'h10,  // M = M & ~bit
    NALU_OP_PORT_IN       = 5'h11,  // A = port
    NALU_OP_PORT_OUT      = 5'h12   // Port = A
  } nalu_op_t;

  // ----------------------------------------------------------------
  // One-hot phases of the machine cycle
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    NALU_PH_0 = 3'h1,
    NALU_PH_1 = 3'h2,
    NALU_PH_2 = 3'h4
  } nalu_phase_t;

  // ----------------------------------------------------------------
  // Whole state of the datapath
  // ----------------------------------------------------------------
  typedef struct packed {
    nalu_phase_t             phase;      // Machine-cycle phase
    logic [`NALU_WIDTH-1:0]  acc;        // Working register
    logic                    carry_flag; // Carry flag
    logic                    skip;       // Compare result of last cycle
    logic [`NALU_WIDTH-1:0]  mem_data;   // Nibble to write to memory
    logic                    mem_we;     // Memory write pulse
    logic [`NALU_WIDTH-1:0]  port_data;  // Nibble driven to the port
    logic                    port_we;    // Port write pulse
  } nalu_state_t;

endpackage

// file: core/nalu_unit_if.sv
/*
  Bundle between the datapath core and its logic unit.
  Assumes both ends share the package types; purely combinational.
*/
`timescale 1ns/1ps
`include "nalu_map.svh"

interface nalu_unit_if;
  nalu_pkg::nalu_op_t             op;      // Operation to evaluate
  logic [`NALU_WIDTH-1:0]         a;       // Working register
  logic [`NALU_WIDTH-1:0]         m;       // Memory nibble
  logic [`NALU_WIDTH-1:0]         imm;     // Immediate nibble
  logic                           cin;     // Incoming carry
  logic [`NALU_BIT_SEL_W-1:0]     bit_sel; // Bit number for bit operations
  logic [`NALU_WIDTH-1:0]         result;  // Unit result
  logic                           cout;    // Carry produced
  logic                           equal;   // Compare result

  modport unit (input op, a, m, imm, cin, bit_sel, output result, cout, equal);
  modport core (output op, a, m, imm, cin, bit_sel, input result, cout, equal);
endinterface

// file: tb/nalu_tb.sv
/*
  Self-checking bench of the nibble datapath. It issues decoder operations
  on the falling edge and checks the working register, flags and pulses.
  Assumes nalu_pkg is compiled first and core/ is on the include path.
*/
`timescale 1ns/1ps
`include "nalu_map.svh"

module tb;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic                      clk_in;        // 100 MHz system clock
  logic                      reset_n_in;    // Async reset, active low
  nalu_pkg::nalu_op_t        op_in;         // Operation to issue
  logic [`NALU_WIDTH-1:0]    mem_in;        // Memory nibble
  logic [`NALU_WIDTH-1:0]    imm_in;        // Immediate nibble
  logic [`NALU_BIT_SEL_W-1:0] bit_sel_in;   // Bit number
  logic [`NALU_WIDTH-1:0]    port_in;       // Port input nibble
  logic                      mcycle_out;    // Op-taking phase
  logic [`NALU_WIDTH-1:0]    acc_out;       // Working register
  logic                      carry_out;     // Carry flag
  logic                      skip_out;      // Compare matched
  logic [`NALU_WIDTH-1:0]    mem_data_out;  // Nibble to memory
  logic                      mem_we_out;    // Memory write pulse
  logic [`NALU_WIDTH-1:0]    port_data_out; // Nibble to port
  logic                      port_we_out;   // Port write pulse
  int                        errors;        // Mismatch count
  int                        checks;        // Comparison count
  int                        cycles;        // Hang guard

  nalu_datapath uut (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .op_in         (op_in),
    .mem_in        (mem_in),
    .imm_in        (imm_in),
    .bit_sel_in    (bit_sel_in),
    .port_in       (port_in),
    .mcycle_out    (mcycle_out),
    .acc_out       (acc_out),
    .carry_out     (carry_out),
    .skip_out      (skip_out),
    .mem_data_out  (mem_data_out),
    .mem_we_out    (mem_we_out),
    .port_data_out (port_data_out),
    .port_we_out   (port_we_out)
  );

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Whole run needs about two hundred clocks; a stuck phase counter stops here
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles >= 3000)
    begin
      errors++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    begin
      checks++;
      if (seen !== exp)
      begin
        errors++;
        $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask

  // Waits for the op-taking phase, presents one op, returns on the next falling edge
  task automatic exec(input nalu_pkg::nalu_op_t op, input logic [3:0] m,
                      input logic [3:0] n, input logic [1:0] bs, input logic [3:0] p);
    int k;
    begin
      k = 0;
      while (mcycle_out !== 1'b1 && k < 8)
      begin
        @(negedge clk_in);
        k++;
      end
      chk("mcycle_seen", {7'h00, mcycle_out}, 8'h01);
      op_in = op;
      mem_in = m;
      imm_in = n;
      bit_sel_in = bs;
      port_in = p;
      @(negedge clk_in);
    end
  endtask

  task automatic ld(input logic [3:0] a);
    exec(nalu_pkg::NALU_OP_LOAD_IMM, 4'h0, a, 2'h0, 4'h0);
  endtask

  // Plain branches keep the operation argument a true enum value
  task automatic setc(input logic c);
    if (c)
      exec(nalu_pkg::NALU_OP_SET_CARRY, 4'h0, 4'h0, 2'h0, 4'h0);
    else
      exec(nalu_pkg::NALU_OP_CLEAR_CARRY, 4'h0, 4'h0, 2'h0, 4'h0);
  endtask

  // Counts falling edges until the op-taking phase comes round
  task automatic gap(output int n);
    begin
      n = 0;
      do
      begin
        @(negedge clk_in);
        n++;
      end
      while (mcycle_out !== 1'b1 && n < 8);
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    int n;
    begin
      chk("acc_rst", {4'h0, acc_out}, 8'h00);
      chk("flags_rst", {4'h0, carry_out, skip_out, mem_we_out, port_we_out}, 8'h00);
      chk("mcycle_rst", {7'h00, mcycle_out}, 8'h00);
      reset_n_in = 1'b1;
      gap(n);
      chk("first_mcycle", 8'(n), 8'h02);
    end
  endtask

  task automatic t_timing();
    int n;
    begin
      gap(n);
      chk("mcycle_period", 8'(n), 8'h03);
      gap(n);
      chk("mcycle_period", 8'(n), 8'h03);
    end
  endtask

  // Set and clear twice each: idempotence and no effect on the register
  task automatic t_carry_ops();
    begin
      ld(4'h6);
      setc(1'b1);
      chk("set_carry", {3'h0, carry_out, acc_out}, 8'h16);
      setc(1'b1);
      chk("set_again", {3'h0, carry_out, acc_out}, 8'h16);
      chk("set_pulses", {6'h00, mem_we_out, port_we_out}, 8'h00);
      setc(1'b0);
      chk("clear_carry", {3'h0, carry_out, acc_out}, 8'h06);
      setc(1'b0);
      chk("clear_again", {3'h0, carry_out, acc_out}, 8'h06);
    end
  endtask

  // Sums, two of the three overflowing, with each carry value: carry must not move
  task automatic t_add_keep();
    begin
      for (int c = 0; c < 2; c++)
      begin
        setc(c[0]);
        ld(4'hF);
        exec(nalu_pkg::NALU_OP_ADD_IMM, 4'h0, 4'h3, 2'h0, 4'h0);
        chk("add_imm", {3'h0, carry_out, acc_out}, {3'h0, c[0], 4'h2});
        exec(nalu_pkg::NALU_OP_ADD_MEM, 4'h9, 4'h0, 2'h0, 4'h0);
        chk("add_mem", {3'h0, carry_out, acc_out}, {3'h0, c[0], 4'hB});
        exec(nalu_pkg::NALU_OP_ADD_MEM, 4'h8, 4'h0, 2'h0, 4'h0);
        chk("add_mem_ovf", {3'h0, carry_out, acc_out}, {3'h0, c[0], 4'h3});
      end
    end
  endtask

  task automatic add_case(input logic [3:0] a, input logic [3:0] m, input logic c,
                          input logic [3:0] ea, input logic ec);
    begin
      setc(c);
      ld(a);
      exec(nalu_pkg::NALU_OP_ADD_MEM_CARRY, m, 4'h0, 2'h0, 4'h0);
      chk("addc_acc", {4'h0, acc_out}, {4'h0, ea});
      chk("addc_carry", {7'h00, carry_out}, {7'h00, ec});
    end
  endtask

  // Boundaries: carry-in alone overflowing, exact 16, no carry out
  task automatic t_add_carry();
    begin
      add_case(4'h9, 4'h8, 1'b1, 4'h2, 1'b1);
      add_case(4'hF, 4'h0, 1'b1, 4'h0, 1'b1);
      add_case(4'h8, 4'h8, 1'b0, 4'h0, 1'b1);
      add_case(4'h7, 4'h8, 1'b0, 4'hF, 1'b0);
      add_case(4'h1, 4'h2, 1'b1, 4'h4, 1'b0);
    end
  endtask

  task automatic t_rotate();
    begin
      setc(1'b0);
      ld(4'h5);
      exec(nalu_pkg::NALU_OP_ROT_RIGHT, 4'h0, 4'h0, 2'h0, 4'h0);
      chk("rot_1", {3'h0, carry_out, acc_out}, 8'h12);
      exec(nalu_pkg::NALU_OP_ROT_RIGHT, 4'h0, 4'h0, 2'h0, 4'h0);
      chk("rot_2", {3'h0, carry_out, acc_out}, 8'h09);
      exec(nalu_pkg::NALU_OP_ROT_RIGHT, 4'h0, 4'h0, 2'h0, 4'h0);
      chk("rot_3", {3'h0, carry_out, acc_out}, 8'h14);
    end
  endtask

  // Logic, compare, bit, transfer, exchange and port operations in a chain
  task automatic t_logic();
    begin
      ld(4'hC);
      exec(nalu_pkg::NALU_OP_AND_MEM, 4'hA, 4'h0, 2'h0, 4'h0);
      chk("and_mem", {4'h0, acc_out}, 8'h08);
      exec(nalu_pkg::NALU_OP_OR_MEM, 4'h3, 4'h0, 2'h0, 4'h0);
      chk("or_mem", {4'h0, acc_out}, 8'h0B);
      exec(nalu_pkg::NALU_OP_CMP_IMM, 4'h0, 4'hB, 2'h0, 4'h0);
      chk("cmp_imm_eq", {7'h00, skip_out}, 8'h01);
      @(negedge clk_in);
      @(negedge clk_in);
      chk("skip_held", {7'h00, skip_out}, 8'h01);
      exec(nalu_pkg::NALU_OP_CMP_IMM, 4'h0, 4'h3, 2'h0, 4'h0);
      chk("cmp_imm_ne", {7'h00, skip_out}, 8'h00);
      exec(nalu_pkg::NALU_OP_CMP_MEM, 4'hB, 4'h0, 2'h0, 4'h0);
      chk("cmp_mem_eq", {7'h00, skip_out}, 8'h01);
      exec(nalu_pkg::NALU_OP_CMP_MEM, 4'hA, 4'h0, 2'h0, 4'h0);
      chk("cmp_mem_ne", {7'h00, skip_out}, 8'h00);
      exec(nalu_pkg::NALU_OP_BIT_SET, 4'h2, 4'h0, 2'h3, 4'h0);
      chk("bit_set", {3'h0, mem_we_out, mem_data_out}, 8'h1A);
      exec(nalu_pkg::NALU_OP_BIT_CLEAR, 4'hF, 4'h0, 2'h0, 4'h0);
      chk("bit_clear", {3'h0, mem_we_out, mem_data_out}, 8'h1E);
      chk("bit_acc", {4'h0, acc_out}, 8'h0B);
      exec(nalu_pkg::NALU_OP_STORE_MEM, 4'h0, 4'h0, 2'h0, 4'h0);
      chk("store", {3'h0, mem_we_out, mem_data_out}, 8'h1B);
      @(negedge clk_in);
      chk("store_pulse", {7'h00, mem_we_out}, 8'h00);
      exec(nalu_pkg::NALU_OP_LOAD_MEM, 4'h5, 4'h0, 2'h0, 4'h0);
      chk("load_mem", {4'h0, acc_out}, 8'h05);
      exec(nalu_pkg::NALU_OP_XCH_MEM, 4'hD, 4'h0, 2'h0, 4'h0);
      chk("xch", {3'h0, mem_we_out, acc_out}, 8'h1D);
      chk("xch_mem", {4'h0, mem_data_out}, 8'h05);
      exec(nalu_pkg::NALU_OP_PORT_OUT, 4'h0, 4'h0, 2'h0, 4'h0);
      chk("port_out", {3'h0, port_we_out, port_data_out}, 8'h1D);
      @(negedge clk_in);
      chk("port_pulse", {7'h00, port_we_out}, 8'h00);
      exec(nalu_pkg::NALU_OP_PORT_IN, 4'h0, 4'h0, 2'h0, 4'h7);
      chk("port_in", {port_data_out, acc_out}, 8'hD7);
      exec(nalu_pkg::NALU_OP_NOP, 4'h3, 4'h3, 2'h0, 4'h3);
      chk("nop", {4'h0, acc_out}, 8'h07);
    end
  endtask

  // Reset in mid-run clears register and carry at once, then the ring restarts
  task automatic t_mid_reset();
    int n;
    begin
      reset_n_in = 1'b0;
      #1;
      chk("mid_rst", {3'h0, carry_out, acc_out}, 8'h00);
      @(negedge clk_in);
      reset_n_in = 1'b1;
      gap(n);
      chk("restart_mcycle", 8'(n), 8'h02);
    end
  endtask

  // ----------------------------------------------------------------
  // Verdict and main sequence
  // ----------------------------------------------------------------
  task automatic complete_run();
    begin
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  initial
  begin
    errors = 0;
    checks = 0;
    cycles = 0;
    reset_n_in = 1'b0;
    op_in = nalu_pkg::NALU_OP_NOP;
    mem_in = 4'h0;
    imm_in = 4'h0;
    bit_sel_in = 2'h0;
    port_in = 4'h0;
    repeat (16) @(posedge clk_in);
    @(negedge clk_in);
    t_reset();
    t_timing();
    t_carry_ops();
    t_add_keep();
    t_add_carry();
    t_rotate();
    t_logic();
    t_mid_reset();
    complete_run();
  end
endmodule // tb
